// [rtl/epis_sense.sv]
// epis_sense.sv - sense, flag and wake logic for two external interrupt
// pins, with its registers on an apb slave.
// assumes: pins are read at the pad whatever the pin direction; the cpu
// pulses irq_ack_* when it vectors; sleep inputs come from the power
// controller; mclk keeps running whenever power-down wake is checked.
//
// Notes on behaviour
// - pins raise requests even when driven outputs
// - level mode requests while pin stays low
// - edges recognised only with io clock running
// - low level detected without any clock
// - io clock stopped in non-idle sleep
// - power-down wake samples level twice, watchdog rate
// - wake after both samples and start-up
// - level vanished by start-up: wake, no interrupt
// - channel one needs global and own enable
// - channel zero needs global and own enable
// - edges found by comparing successive samples
// - pulses over one clock caught while io clock runs
// - channel one sense field in bits 3:2
// - channel zero sense field in bits 1:0
// - enables at bit 7 and bit 6
// - event sets flag; vector or write-one clears
// - flag reads cleared in level mode
`include "epis_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module epis_sense #(
  parameter int unsigned ADDR_W      = 12,                // apb address
  parameter int unsigned STARTUP_CYC = `EPIS_STARTUP_CYC  // start-up
) (
  input  wire logic              mclk,              // 10 MHz clock
  input  wire logic              resetn,            // async reset, low
  input  wire logic              psel,              // apb select
  input  wire logic              penable,           // apb enable
  input  wire logic              pwrite,            // apb direction
  input  wire logic [ADDR_W-1:0] paddr,             // apb byte address
  input  wire logic [31:0]       pwdata,            // apb write data
  output logic      [31:0]       prdata,            // apb read data
  output logic                   pready,            // apb ready
  output logic                   pslverr,           // unmapped access
  input  wire logic              ext_irq_pin_zero,  // pad level, pin 0
  input  wire logic              ext_irq_pin_one,   // pad level, pin 1
  input  wire logic              irq_ack_zero,      // vector taken, 0
  input  wire logic              irq_ack_one,       // vector taken, 1
  input  wire logic              sleep_active,      // cpu is asleep
  input  wire logic              sleep_is_idle,     // sleep is idle
  input  wire logic              sleep_is_pdown,    // sleep is pdown
  output logic                   irq_req_zero,      // request, ch 0
  output logic                   irq_req_one,       // request, ch 1
  output logic                   io_clk_run,        // io clock on
  output logic                   wake_async,        // clockless wake
  output logic                   wake_req           // pdown wake done
);

  // ------------------------------------------------------------
  // constants at the widths they meet
  // ------------------------------------------------------------
  localparam logic [15:0] SU_LAST  = 16'(STARTUP_CYC - 1);
  localparam logic [3:0]  WDT_LAST = 4'(`EPIS_WDT_CYC - 1);

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------

  // sense code of one channel out of the control byte
  function automatic epis_pkg::epis_sense_e sense_of(
    input logic [7:0] ctl,
    input logic       ch
  );
    if (ch) begin
      sense_of = epis_pkg::epis_sense_e'(
        ctl[`EPIS_SENSE_ONE_HI:`EPIS_SENSE_ONE_LO]);
    end else begin
      sense_of = epis_pkg::epis_sense_e'(
        ctl[`EPIS_SENSE_ZERO_HI:`EPIS_SENSE_ZERO_LO]);
    end
  endfunction

  // one-hot register select, used by read and write paths
  function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
    reg_sel = 5'h00;
    reg_sel[0] = (a == ADDR_W'(`EPIS_OFF_MCU_CONTROL));
    reg_sel[1] = (a == ADDR_W'(`EPIS_OFF_GEN_IRQ_CTL));
    reg_sel[2] = (a == ADDR_W'(`EPIS_OFF_GEN_IRQ_FLAGS));
    reg_sel[3] = (a == ADDR_W'(`EPIS_OFF_CPU_STATUS));
    reg_sel[4] = (a == ADDR_W'(`EPIS_OFF_PIN_STATUS));
  endfunction

  // ------------------------------------------------------------
  // state and per-channel wires
  // ------------------------------------------------------------
  epis_pkg::epis_state_s st;       // registered state
  epis_pkg::epis_state_s next_st;  // next state

  logic [1:0] pin_raw;    // pad levels, never gated by direction
  logic [1:0] pin_sync;   // synchronised levels
  logic [1:0] is_level;   // channel in low-level mode
  logic [1:0] flag_set;   // edge event qualified by io clock
  logic [1:0] flag_clr;   // any clear source
  logic [1:0] ack;        // vector acknowledge per channel
  logic [1:0] lvl_req;    // level term of each request
  logic [1:0] irq_req;    // request vector
  logic [4:0] sel;        // current register select
  logic       wr_acc;     // apb write access phase
  logic       rd_setup;   // apb read setup phase
  logic       lvl_allow;  // level requests not held back by wake

  // pad levels go straight in; a pin driven as output still counts
  assign pin_raw = {ext_irq_pin_one, ext_irq_pin_zero};
  assign ack     = {irq_ack_one, irq_ack_zero};

  // io clock is halted in every sleep mode other than idle
  assign io_clk_run = !sleep_active || sleep_is_idle;

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  epis_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (pin_raw),
    .dout   (pin_sync)
  );

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  assign sel      = reg_sel(paddr);
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;                       // no wait states
  assign pslverr  = psel && penable && !(|sel); // unmapped address

  // level requests wait while power-down wake is qualifying, and stay
  // off after a wake whose level vanished during start-up
  assign lvl_allow = (st.wake_state == epis_pkg::EPIS_WK_IDLE) ||
                     ((st.wake_state == epis_pkg::EPIS_WK_DONE) &&
                      st.wake_irq_ok);

  // ------------------------------------------------------------
  // per-channel sense logic
  // ------------------------------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_chan
    epis_pkg::epis_sense_e sense;  // decoded mode of this channel
    logic                  en;     // own enable of this channel
    logic                  evt;    // edge event of this channel

    assign sense = sense_of(st.mcu_control, 1'(c));
    assign en    = st.irq_enable[c];
    assign is_level[c] = (sense == epis_pkg::EPIS_SENSE_LOW);

    // compare this sample with the last; raw transitions are not used
    always_comb begin
      unique case (sense)
        epis_pkg::EPIS_SENSE_ANY: begin
          evt = pin_sync[c] ^ st.prev[c];
        end
        epis_pkg::EPIS_SENSE_FALL: begin
          evt = st.prev[c] && !pin_sync[c];
        end
        epis_pkg::EPIS_SENSE_RISE: begin
          evt = !st.prev[c] && pin_sync[c];
        end
        epis_pkg::EPIS_SENSE_LOW: begin
          evt = 1'b0;
        end
      endcase
    end

    // edges only count while the io clock runs
    assign flag_set[c] = evt && io_clk_run;

    // vector, write-one, or level mode clear the flag
    assign flag_clr[c] = ack[c] || is_level[c] ||
      (wr_acc && sel[2] && pwdata[`EPIS_FLAG_ZERO_BIT + c]);

    // raw pin, no clock in the path, so it works in deep sleep
    assign lvl_req[c] = is_level[c] && !pin_raw[c];

    // flag or live level, gated by own and global enable
    assign irq_req[c] = (st.flags[c] || (lvl_req[c] && lvl_allow)) &&
                        en && st.gie;
  end

  assign irq_req_zero = irq_req[0];
  assign irq_req_one  = irq_req[1];

  // clockless wake source for sleep modes that stop mclk users
  assign wake_async = |(lvl_req & st.irq_enable);
  assign wake_req   = (st.wake_state == epis_pkg::EPIS_WK_DONE);
  assign prdata     = st.prdata;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [1:0] held;  // checked channels still showing low level
    logic       tick;  // one watchdog oscillator period elapsed
    held = 2'h0;
    tick = 1'b0;
    next_st = st;

    // register writes take effect in the access phase
    if (wr_acc && sel[0]) begin
      next_st.mcu_control = pwdata[7:0];
    end
    if (wr_acc && sel[1]) begin
      next_st.irq_enable = {pwdata[`EPIS_EN_ONE_BIT],
                            pwdata[`EPIS_EN_ZERO_BIT]};
    end
    if (wr_acc && sel[3]) begin
      next_st.gie = pwdata[`EPIS_GIE_BIT];
    end

    // a set in the same cycle as a clear wins
    next_st.flags = flag_set | (st.flags & ~flag_clr);
    next_st.prev  = pin_sync;

    // power-down wake qualification at the watchdog rate
    held = st.wake_chan & is_level & st.irq_enable & ~pin_sync;
    tick = (st.wdt_div == WDT_LAST);
    unique case (st.wake_state)
      epis_pkg::EPIS_WK_IDLE: begin
        if (sleep_active && sleep_is_pdown &&
            |(is_level & st.irq_enable & ~pin_sync)) begin
          next_st.wake_state = epis_pkg::EPIS_WK_SAMPLE;
          next_st.wake_chan  = is_level & st.irq_enable & ~pin_sync;
          next_st.wdt_div    = 4'h0;
          next_st.smp_cnt    = 1'b0;
        end
      end
      epis_pkg::EPIS_WK_SAMPLE: begin
        next_st.wdt_div = tick ? 4'h0 : st.wdt_div + 4'h1;
        if (tick) begin
          if (!(|held)) begin
            // noise: level went away before two samples
            next_st.wake_state = epis_pkg::EPIS_WK_IDLE;
          end else if (st.smp_cnt) begin
            next_st.wake_state = epis_pkg::EPIS_WK_STARTUP;
            next_st.su_cnt     = 16'h0000;
          end else begin
            next_st.smp_cnt = 1'b1;
          end
        end
      end
      epis_pkg::EPIS_WK_STARTUP: begin
        next_st.su_cnt = st.su_cnt + 16'h0001;
        if (st.su_cnt == SU_LAST) begin
          next_st.wake_state  = epis_pkg::EPIS_WK_DONE;
          next_st.wake_irq_ok = |held;
        end
      end
      epis_pkg::EPIS_WK_DONE: begin
        if (!sleep_active) begin
          next_st.wake_state  = epis_pkg::EPIS_WK_IDLE;
          next_st.wake_irq_ok = 1'b0;
        end
      end
      default: begin
        // illegal one-hot code: recover to idle
        next_st.wake_state = epis_pkg::EPIS_WK_IDLE;
      end
    endcase

    // read data captured in setup so it is stable for the access
    if (rd_setup) begin
      next_st.prdata = `EPIS_PRDATA_RST;
      if (sel[0]) begin
        next_st.prdata[7:0] = st.mcu_control;
      end
      if (sel[1]) begin
        next_st.prdata[`EPIS_EN_ONE_BIT]  = st.irq_enable[1];
        next_st.prdata[`EPIS_EN_ZERO_BIT] = st.irq_enable[0];
      end
      if (sel[2]) begin
        // level-mode channels always read as cleared
        next_st.prdata[`EPIS_FLAG_ONE_BIT] =
          st.flags[1] && !is_level[1];
        next_st.prdata[`EPIS_FLAG_ZERO_BIT] =
          st.flags[0] && !is_level[0];
      end
      if (sel[3]) begin
        next_st.prdata[`EPIS_GIE_BIT] = st.gie;
      end
      if (sel[4]) begin
        next_st.prdata[1:0]  = pin_sync;
        next_st.prdata[3:2]  = irq_req;
        next_st.prdata[4]    = io_clk_run;
        next_st.prdata[11:8] = st.wake_state;
      end
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st             <= '0;
      st.mcu_control <= `EPIS_MCU_CONTROL_RST;
      st.prev        <= 2'h3;  // pins idle high
      st.wake_state  <= epis_pkg::EPIS_WK_IDLE;
      st.prdata      <= `EPIS_PRDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic tick_seen;  // divider at its last count, for checks only
  assign tick_seen = (st.wdt_div == WDT_LAST);

  sequence s_fall_seen;
    !is_level[0] && st.mcu_control[1:0] == 2'h2 &&
    st.prev[0] && !pin_sync[0] && io_clk_run;
  endsequence

  sequence s_startup_run;
    (st.wake_state == epis_pkg::EPIS_WK_STARTUP) [*8];
  endsequence

  a_fall_sets_flag: assert property (
    s_fall_seen |=> st.flags[0])
    else $error("falling edge did not set flag zero");

  a_no_edge_stopped: assert property (
    !io_clk_run && !st.flags[1] |=> !st.flags[1])
    else $error("flag one set while io clock stopped");

  a_any_change_one: assert property (
    st.mcu_control[3:2] == 2'h1 && io_clk_run &&
    $changed(pin_sync[1]) |=> st.flags[1])
    else $error("pin change missed in any-change mode");

  a_level_flag_clr: assert property (
    st.mcu_control[3:2] == 2'h0 |=> !st.flags[1])
    else $error("flag one held in level mode");

  a_w1c_clears: assert property (
    wr_acc && sel[2] && pwdata[6] && !flag_set[0] |=> !st.flags[0])
    else $error("write one did not clear flag zero");

  a_set_beats_clr: assert property (
    flag_set[1] && ack[1] |=> st.flags[1])
    else $error("clear won over set on flag one");

  a_gie_gates: assert property (
    !st.gie |-> !irq_req_one && !irq_req_zero)
    else $error("request with global enable off");

  a_level_request: assert property (
    is_level[0] && !pin_raw[0] && st.irq_enable[0] && st.gie &&
    st.wake_state == epis_pkg::EPIS_WK_IDLE |-> irq_req_zero)
    else $error("low level not requesting on channel zero");

  a_two_samples: assert property (
    $rose(st.wake_state == epis_pkg::EPIS_WK_STARTUP) |->
    $past(st.smp_cnt) && $past(tick_seen))
    else $error("start-up entered without two samples");

  a_startup_holds: assert property (
    $rose(st.wake_state == epis_pkg::EPIS_WK_STARTUP) |-> s_startup_run)
    else $error("start-up time cut short");

  a_no_irq_vanish: assert property (
    st.wake_state == epis_pkg::EPIS_WK_DONE && !st.wake_irq_ok &&
    is_level[1] |-> !irq_req_one)
    else $error("level interrupt after vanished wake level");

endmodule // epis_sense

`default_nettype wire

// [rtl/epis_consts.svh]
// epis_consts.svh - offsets, field positions, reset values and timing
// counts for the external pin interrupt sense block.
// assumes: included by bare name; no processes live here.
`ifndef EPIS_CONSTS_SVH
`define EPIS_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets on the apb bus
// ------------------------------------------------------------
`define EPIS_OFF_MCU_CONTROL    12'h000
`define EPIS_OFF_GEN_IRQ_CTL    12'h004
`define EPIS_OFF_GEN_IRQ_FLAGS  12'h008
`define EPIS_OFF_CPU_STATUS     12'h00C
`define EPIS_OFF_PIN_STATUS     12'h010

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define EPIS_SENSE_ONE_HI   3
`define EPIS_SENSE_ONE_LO   2
`define EPIS_SENSE_ZERO_HI  1
`define EPIS_SENSE_ZERO_LO  0
`define EPIS_EN_ONE_BIT     7
`define EPIS_EN_ZERO_BIT    6
`define EPIS_FLAG_ONE_BIT   7
`define EPIS_FLAG_ZERO_BIT  6
`define EPIS_GIE_BIT        7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define EPIS_MCU_CONTROL_RST  8'h00
`define EPIS_PRDATA_RST       32'h0000_0000

// ------------------------------------------------------------
// timing: times in ns, counts derived from the 100 ns clock
// ------------------------------------------------------------
`define EPIS_CLK_PERIOD_NS  100
`define EPIS_WDT_PERIOD_NS  1000
`define EPIS_WDT_CYC  (`EPIS_WDT_PERIOD_NS / `EPIS_CLK_PERIOD_NS)
`define EPIS_STARTUP_NS     4000000
`define EPIS_STARTUP_CYC \
  ((`EPIS_STARTUP_NS + `EPIS_CLK_PERIOD_NS - 1) / `EPIS_CLK_PERIOD_NS)

`endif

// [rtl/epis_pkg.sv]
// epis_pkg.sv - types shared by the external pin interrupt sense block.
// assumes: compiled before every module that names epis_pkg::.
package epis_pkg;

  // ------------------------------------------------------------
  // per-channel sense selection, as coded in the control field
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EPIS_SENSE_LOW  = 2'h0,   // low level
    EPIS_SENSE_ANY  = 2'h1,   // any logical change
    EPIS_SENSE_FALL = 2'h2,   // falling edge
    EPIS_SENSE_RISE = 2'h3    // rising edge
  } epis_sense_e;

  // ------------------------------------------------------------
  // power-down wake qualification, one-hot
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    EPIS_WK_IDLE    = 4'h1,   // nothing pending
    EPIS_WK_SAMPLE  = 4'h2,   // watchdog-rate sampling
    EPIS_WK_STARTUP = 4'h4,   // start-up time running
    EPIS_WK_DONE    = 4'h8    // awake, waiting for sleep to drop
  } epis_wake_e;

  // ------------------------------------------------------------
  // whole state of the sense block
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  mcu_control;  // sense fields in low nibble
    logic [1:0]  irq_enable;   // [1] channel one, [0] channel zero
    logic [1:0]  flags;        // sticky edge flags
    logic        gie;          // global interrupt enable
    logic [1:0]  prev;         // previous synced pin sample
    epis_wake_e  wake_state;   // wake qualification state
    logic [1:0]  wake_chan;    // channels that started the check
    logic [3:0]  wdt_div;      // watchdog tick divider
    logic        smp_cnt;      // samples taken so far
    logic [15:0] su_cnt;       // start-up counter
    logic        wake_irq_ok;  // level still held at start-up end
    logic [31:0] prdata;       // apb read data
  } epis_state_s;

endpackage

// [rtl/epis_sync.sv]
// epis_sync.sv - two-flop synchroniser for the interrupt pins.
// assumes: din may change at any time; dout is used on mclk only.
`timescale 1ns/10ps
`default_nettype none

module epis_sync #(
  parameter int unsigned W       = 2,    // number of bits
  parameter logic [W-1:0] RST_VAL = '1   // idle level of pins
) (
  input  wire logic         mclk,    // block clock
  input  wire logic         resetn,  // async reset, low
  input  wire logic [W-1:0] din,     // raw pin levels
  output logic      [W-1:0] dout     // synchronised levels
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;    // first stage, read only by stable
    logic [W-1:0] stable;  // second stage
  } epis_sync_s;

  epis_sync_s st;       // registered state
  epis_sync_s next_st;  // next state

  // shift the pin through both stages
  always_comb begin
    next_st        = st;
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  // reset to the idle level so no false edge follows release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_sync_two_stage: assert property (
    @(posedge mclk) disable iff (!resetn)
    $past(resetn, 2) |-> dout == $past(din, 2))
    else $error("synchroniser output is not din two cycles late");

endmodule // epis_sync

`default_nettype wire

// [dv/epis_pin_src.sv]
// epis_pin_src.sv - model of the sources that drive both irq pins.
// assumes: pads have pull-ups, so a released pin reads high.
`timescale 1ns/10ps
`default_nettype none

module epis_pin_src (
  input  wire logic       mclk,  // block clock
  output var  logic [1:0] pins   // {one, zero} pad levels
);
  // pull-up level until a source pulls low
  initial pins = 2'b11;

  // change one pin just after an edge; a low stays until the caller
  // releases it, so a level request outlives instruction and wake-up
  task automatic drive(input int ch, input logic v);
    @(posedge mclk);
    pins[ch] <= v;
  endtask
endmodule  // epis_pin_src

`default_nettype wire

// [dv/tb_external_pin_interrupt_sense.sv]
// tb_external_pin_interrupt_sense.sv - apb-driven checks of the block.
// assumes: design files and epis_pin_src are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_external_pin_interrupt_sense;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        mclk, resetn, psel, penable, pwrite, err;
  logic [11:0] paddr;   // apb byte address
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rq0, rq1, ioc, wka, wkr;
  logic [1:0]  pins, ack;  // pad levels, vector pulses
  logic [2:0]  slp;        // {active, idle, pdown}
  int          n_mismatch, checks, c, m, i;

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  epis_pin_src src (.mclk(mclk), .pins(pins));

  // short start-up so the wake check stays quick
  epis_sense #(.STARTUP_CYC(16)) uut (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin_zero(pins[0]),
    .ext_irq_pin_one(pins[1]), .irq_ack_zero(ack[0]),
    .irq_ack_one(ack[1]), .sleep_active(slp[2]),
    .sleep_is_idle(slp[1]), .sleep_is_pdown(slp[0]),
    .irq_req_zero(rq0), .irq_req_one(rq1), .io_clk_run(ioc),
    .wake_async(wka), .wake_req(wkr));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      n_mismatch++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    ack = 2'b00;
    slp = 3'b000;
    n_mismatch = 0;
    checks = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    rdc(12'h000, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk(err, 1);
    wr(12'h00C, 32'h0000_0080);
    wr(12'h004, 32'h0000_00C0);
    // every edge mode on both channels
    for (c = 0; c < 2; c++) begin
      for (m = 1; m < 4; m++) begin
        wr(12'h000, m << (2 * c));
        src.drive(c, 1'b0);
        repeat (4) @(posedge mclk);
        rdc(12'h008, 32'(m != 3) << (6 + c));
        chk(c ? rq1 : rq0, m != 3);
        src.drive(c, 1'b1);
        repeat (4) @(posedge mclk);
        rdc(12'h008, 32'h1 << (6 + c));
        // vector clears channel zero, write-one channel one
        if (c == 0) begin
          ack[0] <= 1'b1;
          @(posedge mclk);
          ack[0] <= 1'b0;
        end else begin
          wr(12'h008, 32'h0000_0080);
        end
        rdc(12'h008, 32'h0000_0000);
      end
    end
    // level mode on channel zero
    wr(12'h000, 32'h0000_0000);
    src.drive(0, 1'b0);
    @(negedge mclk);
    chk(rq0, 1);
    rdc(12'h008, 32'h0000_0000);
    wr(12'h00C, 32'h0000_0000);
    @(negedge mclk);
    chk(rq0, 0);
    wr(12'h00C, 32'h0000_0080);
    // deep sleep: edges lost, level still wakes
    slp <= 3'b100;
    @(negedge mclk);
    chk(ioc, 0);
    chk(wka, 1);
    wr(12'h000, 32'h0000_0008);
    src.drive(1, 1'b0);
    repeat (4) @(posedge mclk);
    rdc(12'h008, 32'h0000_0000);
    slp <= 3'b101;
    for (i = 0; i < 300 && wkr !== 1'b1; i++) @(posedge mclk);
    chk(wkr, 1);
    chk(rq0, 1);
    slp <= 3'b000;
    repeat (2) @(posedge mclk);
    // second wake: level gone before start-up ends, back after it
    slp <= 3'b101;
    repeat (25) @(posedge mclk);
    src.drive(0, 1'b1);
    for (i = 0; i < 300 && wkr !== 1'b1; i++) @(posedge mclk);
    chk(wkr, 1);
    src.drive(0, 1'b0);
    @(negedge mclk);
    chk(rq0, 0);
    slp <= 3'b000;
    complete_run();
  end
endmodule  // tb_external_pin_interrupt_sense

`default_nettype wire
